//--- include/lcd_pkg.sv
// Function
// RL1: Backplane select 00..11 drives backplanes 0, 0-1, 0-2 or all four.
// RL2: Active backplane pin ignores its direction bit; otherwise direction governs.
// RL3: Segment pin drives only when its enable bit is 1, overriding direction.
// RL4: After reset every segment-capable pin is ordinary I/O.
// RL5: One storage bit per pixel, per backplane and segment pair, drives it.
// RL6: Undisplayed pixel bits stay ordinary readable and writable storage.
// RL7: Frame rate is source over prescaler times 32 times backplanes times multiplier.
// RL8: Timing clock selects system clock over 256, crystal or internal oscillator.
// RL9: Sleep with shutdown select set stops at once, all outputs grounded.
// RL10: Clearing enable finishes the frame, clears active flag, optional interrupt.
// RL11: After the end-of-frame disable the pins return to digital port use.
// RL12: Software clears enable, waits for active flag 0, then sleeps.
// RL13: Shutdown clear, system clock source: sleep freezes the last pattern.
// RL14: Shutdown clear, slow clock source: keeps refreshing; data frozen while asleep.
// RL15: Running in sleep with interrupt enable set wakes at the next frame boundary.
// RL16: Software should drive display pins low through port settings afterwards.
// RL17: Active flag is set while enabled and generating frames; read-only.
// RL18: Interrupt only in frame-synchronised waveform, non-static mode.
package lcd_pkg;

    localparam int NUM_BP = 4;
    localparam int NUM_SEG = 32;
    localparam int PIX_BITS = NUM_BP * NUM_SEG;
    localparam int TICK_PER_PHASE = 32;
    localparam int SYS_DIV = 256;
    localparam logic [3:0] FRAME_DIV_RESET = 4'h0;

    typedef enum logic [1:0] {
        SRC_SYS_DIV,
        SRC_CRYSTAL,
        SRC_INTERNAL
    } clk_src_t;

    typedef struct packed {
        logic display_enable_bit;
        logic sleep_shutdown_select;
        logic display_interrupt_enable;
        logic frame_sync_wave;
        logic [1:0] backplane_count_select;
        logic [1:0] clk_sel;
        logic [3:0] frame_divider_field;
    } display_ctrl_t;

endpackage

//--- rtl/lcd_tick_gen.sv
`timescale 1ns/1ps
module lcd_tick_gen #(
    parameter int SYS_DIV = lcd_pkg::SYS_DIV
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Sources
    input wire logic [1:0] clk_sel,
    input wire logic crystal_clk,
    input wire logic internal_clk,
    // Tick out
    output logic tick
);
    typedef struct packed {
        logic [7:0] div;
        logic [1:0] xs;
        logic [1:0] is;
        logic xl;
        logic il;
        logic tick;
    } tick_state_t;

    tick_state_t st_r, st_nxt;

    // Slow sources pass two flops before edge detection [RL8]
    always_comb begin
        st_nxt = st_r;
        st_nxt.xs = {st_r.xs[0], crystal_clk};
        st_nxt.is = {st_r.is[0], internal_clk};
        st_nxt.xl = st_r.xs[1];
        st_nxt.il = st_r.is[1];
        st_nxt.div = st_r.div + 8'h01;
        case (clk_sel)
            lcd_pkg::SRC_CRYSTAL: st_nxt.tick = st_r.xs[1] & ~st_r.xl;
            lcd_pkg::SRC_INTERNAL: st_nxt.tick = st_r.is[1] & ~st_r.il;
            default: st_nxt.tick = (st_r.div == 8'(SYS_DIV - 1)); // [RL8]
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule // lcd_tick_gen

//--- rtl/lcd_drive_sequencer.sv
`timescale 1ns/1ps
module lcd_drive_sequencer #(
    parameter int NUM_SEG = lcd_pkg::NUM_SEG
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Control
    input wire lcd_pkg::display_ctrl_t ctrl,
    input wire logic [NUM_SEG-1:0] segment_enable_regs,
    input wire logic core_sleep,
    // Pixel storage access
    input wire logic pix_wr,
    input wire logic [6:0] pix_addr,
    input wire logic pix_wdata,
    output logic pix_rdata,
    // Slow clock pins
    input wire logic low_speed_crystal_clock,
    input wire logic low_freq_internal_clock,
    // Port settings for digital use
    input wire logic [lcd_pkg::NUM_BP-1:0] bp_dir_bits,
    input wire logic [NUM_SEG-1:0] pin_direction_bits,
    // Pin side
    output logic [lcd_pkg::NUM_BP-1:0] bp_drive,
    output logic [lcd_pkg::NUM_BP-1:0] bp_level,
    output logic [NUM_SEG-1:0] seg_drive,
    output logic [NUM_SEG-1:0] seg_level,
    output logic [lcd_pkg::NUM_BP-1:0] bp_port_out_en,
    output logic [NUM_SEG-1:0] seg_port_out_en,
    output logic low_current,
    // Status
    output logic display_active_flag,
    output logic frame_irq,
    output logic wake_req
);
    localparam int PB = lcd_pkg::NUM_BP * NUM_SEG;

    typedef struct packed {
        logic [PB-1:0] pix;
        logic active;
        logic [3:0] pre;
        logic [5:0] sub;
        logic [1:0] phase;
        logic [1:0] mult;
        logic invert;
        logic [lcd_pkg::NUM_BP-1:0] bpd;
        logic [lcd_pkg::NUM_BP-1:0] bpl;
        logic [NUM_SEG-1:0] sgd;
        logic [NUM_SEG-1:0] sgl;
        logic [lcd_pkg::NUM_BP-1:0] bpo;
        logic [NUM_SEG-1:0] sgo;
        logic lowc;
        logic rd;
        logic irq;
        logic wake;
        logic [1:0] sls;
    } seq_state_t;

    seq_state_t st_r, st_nxt;
    logic tick;

    lcd_tick_gen u_tick (
        .mclk(mclk),
        .resetn(resetn),
        .clk_sel(ctrl.clk_sel),
        .crystal_clk(low_speed_crystal_clock),
        .internal_clk(low_freq_internal_clock),
        .tick(tick)
    );

    // Active backplane mask from the select field
    function automatic logic [3:0] bp_mask(input logic [1:0] sel);
        case (sel)
            2'h0: bp_mask = 4'h1;
            2'h1: bp_mask = 4'h3;
            2'h2: bp_mask = 4'h7;
            default: bp_mask = 4'hf;
        endcase
    endfunction

    // Multiplier: 4 static, 2 for two, 1 for three or four
    function automatic logic [1:0] mult_last(input logic [1:0] sel);
        case (sel)
            2'h0: mult_last = 2'h3;
            2'h1: mult_last = 2'h1;
            default: mult_last = 2'h0;
        endcase
    endfunction

    logic asleep;
    logic slow_src;
    logic [3:0] mask;
    assign asleep = st_r.sls[1];
    assign slow_src = (ctrl.clk_sel != 2'(lcd_pkg::SRC_SYS_DIV));
    assign mask = bp_mask(ctrl.backplane_count_select);

    always_comb begin
        logic run;
        logic step;
        logic frame_end;
        logic [1:0] last_ph;
        run = 1'b0;
        step = 1'b0;
        frame_end = 1'b0;
        last_ph = ctrl.backplane_count_select;
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.wake = 1'b0;
        // Sleep comes from the core's domain: two flops before use
        st_nxt.sls = {st_r.sls[0], core_sleep};
        // Writes blocked while asleep: pixels are frozen [RL14]
        // All bits remain storage, displayed or not [RL6]
        if (pix_wr && !asleep) begin
            st_nxt.pix[pix_addr] = pix_wdata;
        end
        st_nxt.rd = st_r.pix[pix_addr];
        // Shutdown stops at once; sys clock freezes in sleep [RL9] [RL13]
        run = st_r.active &&
              !(asleep && (ctrl.sleep_shutdown_select || !slow_src)); // [RL14]
        step = run && tick;
        if (step) begin
            // Phase length: prescaler x 32 x multiplier ticks [RL7]
            st_nxt.pre = st_r.pre + 4'h1;
            if (st_r.pre >= ctrl.frame_divider_field) begin
                st_nxt.pre = 4'h0;
                st_nxt.sub = st_r.sub + 6'h01;
                if (st_r.sub == 6'(lcd_pkg::TICK_PER_PHASE - 1)) begin
                    st_nxt.sub = 6'h00;
                    st_nxt.mult = st_r.mult + 2'h1;
                    if (st_r.mult == mult_last(ctrl.backplane_count_select)) begin
                        st_nxt.mult = 2'h0;
                        st_nxt.phase = st_r.phase + 2'h1;
                        if (st_r.phase == last_ph) begin
                            st_nxt.phase = 2'h0;
                            st_nxt.invert = ~st_r.invert;
                            frame_end = 1'b1;
                        end
                    end
                end
            end
        end
        if (!st_r.active && ctrl.display_enable_bit && !asleep) begin
            st_nxt.active = 1'b1; // [RL17]
            st_nxt.pre = 4'h0;
            st_nxt.sub = 6'h00;
            st_nxt.mult = 2'h0;
            st_nxt.phase = 2'h0;
        end else if (frame_end && !ctrl.display_enable_bit) begin
            st_nxt.active = 1'b0; // [RL10] [RL17]
        end
        // Interrupt only for frame-sync wave, non-static [RL18] [RL10]
        if (frame_end && ctrl.frame_sync_wave &&
            ctrl.backplane_count_select != 2'h0) begin
            st_nxt.irq = 1'b1;
            st_nxt.wake = asleep && ctrl.display_interrupt_enable; // [RL15]
        end
        st_nxt.lowc = asleep && ctrl.sleep_shutdown_select; // [RL9]
        for (int b = 0; b < lcd_pkg::NUM_BP; b++) begin
            // Active backplanes override direction [RL1] [RL2] [RL11]
            st_nxt.bpd[b] = st_nxt.active && mask[b] && !st_nxt.lowc;
            st_nxt.bpo[b] = !(st_nxt.active && mask[b]) && !bp_dir_bits[b];
            st_nxt.bpl[b] = st_nxt.lowc ? 1'b0 :
                            ((st_nxt.phase == 2'(b)) ^ st_nxt.invert);
        end
        for (int s = 0; s < NUM_SEG; s++) begin
            // Enabled segment overrides direction [RL3] [RL4]
            st_nxt.sgd[s] = st_nxt.active && segment_enable_regs[s] &&
                            !st_nxt.lowc;
            st_nxt.sgo[s] = !(st_nxt.active && segment_enable_regs[s]) &&
                            !pin_direction_bits[s];
            // Pixel bit at backplane x 32 + segment [RL5]
            st_nxt.sgl[s] = st_nxt.lowc ? 1'b0 :
                (st_r.pix[{st_nxt.phase, 5'(s)}] ^ st_nxt.invert);
        end
        // Frozen pattern held when halted [RL13]
        if (st_r.active && !run && !st_nxt.lowc) begin
            st_nxt.bpl = st_r.bpl;
            st_nxt.sgl = st_r.sgl;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bp_drive = st_r.bpd;
    assign bp_level = st_r.bpl;
    assign seg_drive = st_r.sgd;
    assign seg_level = st_r.sgl;
    assign bp_port_out_en = st_r.bpo;
    assign seg_port_out_en = st_r.sgo;
    assign low_current = st_r.lowc;
    assign display_active_flag = st_r.active;
    assign frame_irq = st_r.irq;
    assign wake_req = st_r.wake;
    assign pix_rdata = st_r.rd;
endmodule // lcd_drive_sequencer

//--- test/lcd_glass_model.sv
`timescale 1ns/1ps
// ====
// Passive glass: a pixel sees the voltage across its two lines
module lcd_glass_model (
    // Lines from the sequencer
    input wire logic [3:0] bp_drive,
    input wire logic [3:0] bp_level,
    input wire logic [31:0] seg_drive,
    input wire logic [31:0] seg_level,
    // Lit pixels, backplane*32+segment
    output logic [127:0] lit
);
    always_comb begin
        for (int i = 0; i < 128; i++) begin
            lit[i] = bp_drive[i/32] & seg_drive[i%32]
                & (bp_level[i/32] ^ seg_level[i%32]);
        end
    end
endmodule // lcd_glass_model

//--- test/lcd_drive_sequencer_props.sv
`timescale 1ns/1ps
module lcd_seq_props #(
    parameter int NUM_SEG = 32
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire lcd_pkg::display_ctrl_t ctrl,
    input wire logic [NUM_SEG-1:0] segment_enable_regs,
    input wire logic core_sleep,
    input wire logic [3:0] bp_drive,
    input wire logic [3:0] bp_level,
    input wire logic [NUM_SEG-1:0] seg_drive,
    input wire logic [NUM_SEG-1:0] seg_level,
    input wire logic [3:0] bp_port_out_en,
    input wire logic [NUM_SEG-1:0] seg_port_out_en,
    input wire logic low_current,
    input wire logic display_active_flag,
    input wire logic frame_irq,
    input wire logic wake_req
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ====
    // Pin ownership
    property p_bp_mux;
        bp_drive[3] |-> $past(ctrl.backplane_count_select) == 2'h3;
    endproperty
    a_bp_mux: assert property (p_bp_mux) else $error("bp3 driven");
    property p_seg_en;
        (seg_drive & ~$past(segment_enable_regs)) == '0;
    endproperty
    a_seg_en: assert property (p_seg_en) else $error("seg w/o en");
    property p_bp_port;
        (bp_drive & bp_port_out_en) == 4'h0;
    endproperty
    a_bp_port: assert property (p_bp_port) else $error("bp clash");
    property p_seg_port;
        (seg_drive & seg_port_out_en) == '0;
    endproperty
    a_seg_port: assert property (p_seg_port) else $error("seg clash");
    // ====
    // Sleep, start and stop
    // Two sync flops plus output register, so four cycles of margin
    sequence s_shut_sleep;
        (ctrl.sleep_shutdown_select && core_sleep) [*4];
    endsequence
    property p_shut;
        s_shut_sleep |-> low_current && bp_level == 4'h0 && seg_level == '0;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_act_on;
        $rose(ctrl.display_enable_bit) && !display_active_flag && !core_sleep
            |=> display_active_flag;
    endproperty
    a_act_on: assert property (p_act_on) else $error("not active");
    property p_off;
        $fell(display_active_flag) |-> !ctrl.display_enable_bit;
    endproperty
    a_off: assert property (p_off) else $error("stray stop");
    property p_release;
        $fell(display_active_flag) |-> ##[0:1] bp_drive == 4'h0
            && seg_drive == '0;
    endproperty
    a_release: assert property (p_release) else $error("pins kept");
    property p_irq_mode;
        frame_irq |-> ctrl.frame_sync_wave
            && ctrl.backplane_count_select != 2'h0;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("bad irq");
    property p_wake;
        wake_req |-> ctrl.display_interrupt_enable;
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");
endmodule // lcd_seq_props

bind lcd_drive_sequencer lcd_seq_props #(.NUM_SEG(NUM_SEG)) props_u (
    .mclk(mclk),
    .resetn(resetn),
    .ctrl(ctrl),
    .segment_enable_regs(segment_enable_regs),
    .core_sleep(core_sleep),
    .bp_drive(bp_drive),
    .bp_level(bp_level),
    .seg_drive(seg_drive),
    .seg_level(seg_level),
    .bp_port_out_en(bp_port_out_en),
    .seg_port_out_en(seg_port_out_en),
    .low_current(low_current),
    .display_active_flag(display_active_flag),
    .frame_irq(frame_irq),
    .wake_req(wake_req)
);

//--- test/lcd_drive_sequencer_tb.sv
`timescale 1ns/1ps
module lcd_drive_sequencer_tb;
    logic mclk = 0, resetn = 0, slp = 0, pwr = 0, pwd = 0, xt = 0, lf = 0;
    lcd_pkg::display_ctrl_t ctrl = '0;
    logic [31:0] sen = 32'h0, sdir = 32'hffff_ffff, sgd, sgl, sgo;
    logic [3:0] bdir = 4'hf, bpd, bpl, bpo;
    logic [6:0] pa = 7'h00;
    logic [127:0] lit;
    logic rd, act, irq, wake, lowc;
    int errors = 0, checks = 0, n;
    lcd_drive_sequencer dut_u (.mclk(mclk), .resetn(resetn), .ctrl(ctrl),
        .segment_enable_regs(sen), .core_sleep(slp), .pix_wr(pwr),
        .pix_addr(pa), .pix_wdata(pwd), .pix_rdata(rd),
        .low_speed_crystal_clock(xt), .low_freq_internal_clock(lf),
        .bp_dir_bits(bdir), .pin_direction_bits(sdir), .bp_drive(bpd),
        .bp_level(bpl), .seg_drive(sgd), .seg_level(sgl),
        .bp_port_out_en(bpo), .seg_port_out_en(sgo), .low_current(lowc),
        .display_active_flag(act), .frame_irq(irq), .wake_req(wake));
    lcd_glass_model glass_u (.bp_drive(bpd), .bp_level(bpl),
        .seg_drive(sgd), .seg_level(sgl), .lit(lit));
    always #2.5 mclk = ~mclk;
    // Slow sources: 4 and 14 system cycles per tick
    always #10 xt = ~xt;
    always #35 lf = ~lf;
    // ====
    // Helpers
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic wait_chg();
        logic [3:0] s;
        s = bpl;
        n = 0;
        while (bpl === s && n < 10000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic go_off();
        ctrl.display_enable_bit = 1'b0;
        n = 0;
        while (act !== 1'b0 && n < 40000) begin
            cyc(1);
            n++;
        end
        chk(n < 40000, "stop hung");
        cyc(2);
        chk(bpd === 4'h0 && sgd === 32'h0, "pins kept");
        chk(bpo === ~bdir && sgo === ~sdir, "port use");
    endtask
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ====
    // Scenarios
    task automatic t_pix();
        logic [6:0] a [4] = '{7'h00, 7'h7f, 7'h25, 7'h5a};
        // Ones first, so that zeros read back show the later write and not the reset value
        for (int i = 0; i < 12; i++) begin
            pa = a[i%4];
            pwd = (i < 4) | i[0];
            pwr = (i < 8);
            cyc(2);
            if (i > 7) chk(rd === i[0], "pixel bit");
        end
        pwr = 1'b0;
    endtask
    task automatic t_mux();
        logic [3:0] mk [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
        // Crystal source keeps each closing frame short
        ctrl.clk_sel = 2'h1;
        for (int m = 0; m < 4; m++) begin
            ctrl.backplane_count_select = m[1:0];
            ctrl.display_enable_bit = 1'b1;
            cyc(3);
            chk(act === 1'b1, "not active");
            chk(bpd === mk[m], "backplanes");
            chk(m == 3 || lit[127:96] === 32'h0, "unused lit");
            chk((bpo & mk[m]) === 4'h0, "bp port");
            chk(sgd === sen && sgo === (~sdir & ~sen), "segs");
            go_off();
        end
    endtask
    task automatic t_rate();
        int mx [5] = '{1, 0, 3, 3, 3};
        int lp [5] = '{1, 0, 2, 0, 0};
        int cs [5] = '{1, 1, 1, 2, 0};
        int ex [5] = '{512, 512, 384, 448, 8192};
        for (int i = 0; i < 5; i++) begin
            ctrl.backplane_count_select = mx[i][1:0];
            ctrl.frame_divider_field = lp[i][3:0];
            ctrl.clk_sel = cs[i][1:0];
            ctrl.display_enable_bit = 1'b1;
            wait_chg();
            wait_chg();
            chk(n >= ex[i] - 2 && n <= ex[i] + 2, "rate");
            go_off();
        end
    endtask
    task automatic t_sleep();
        logic [3:0] s;
        ctrl = '{1'b1, 1'b0, 1'b1, 1'b1, 2'h1, 2'h1, 4'h0};
        cyc(3);
        s = bpl;
        slp = 1'b1;
        cyc(4);
        pa = 7'h25;
        pwd = 1'b1;
        pwr = 1'b1;
        cyc(1);
        pwr = 1'b0;
        n = 0;
        while (wake !== 1'b1 && n < 1200) begin
            cyc(1);
            n++;
        end
        chk(n < 1200, "no wake");
        cyc(2);
        chk(bpl !== s, "no refresh");
        slp = 1'b0;
        cyc(4);
        chk(rd === 1'b0, "asleep write");
        // System source in sleep: longer than one phase, nothing moves
        ctrl.clk_sel = 2'h0;
        slp = 1'b1;
        cyc(4);
        s = bpl;
        cyc(17000);
        chk(bpl === s && bpd === 4'h3, "not frozen");
        slp = 1'b0;
        ctrl.clk_sel = 2'h1;
        cyc(4);
        ctrl.sleep_shutdown_select = 1'b1;
        slp = 1'b1;
        cyc(5);
        chk(lowc === 1'b1 && bpl === 4'h0 && sgl === 32'h0, "shut");
        slp = 1'b0;
        ctrl.sleep_shutdown_select = 1'b0;
        cyc(4);
        go_off();
        bdir = 4'h0;
        sdir = 32'h0;
        cyc(2);
        chk(bpo === 4'hf && sgo === 32'hffff_ffff, "port park");
    endtask
    initial begin
        cyc(3);
        resetn = 1'b1;
        cyc(2);
        chk(sgd === 32'h0 && sgo === ~sdir, "reset pins");
        sen = 32'h0000_f0a5;
        sdir = 32'h0f0f_0f0f;
        bdir = 4'h5;
        t_pix();
        t_mux();
        t_rate();
        t_sleep();
        wrap_up();
    end
    initial begin
        // About 60k cycles expected; the system-clock case of the rate test dominates
        #450000;
        errors++;
        $display("[ERR] %0t watchdog", $time);
        wrap_up();
    end
endmodule // lcd_drive_sequencer_tb
